// ==== aagc_device.sv ====
// amplifier end: serial slave with the seven control registers
`include "aagc_defines.svh"

module aagc_device
  import aagc_pkg::*;
#(
  parameter int ATK_STEP_CYC = (`AAGC_ATK_STEP_PS / 1000 + `AAGC_CLK_NS - 1) / `AAGC_CLK_NS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // link
  aagc_if.dev              bus,
  // analog side inputs
  input  wire logic        enablePin,
  input  wire logic        shortEvent,
  input  wire logic        overTemp,
  // control outputs
  output logic             ampActive,
  output logic             softShutdown,
  output logic             noiseGateOn,
  output logic             noiseGateActive,
  output logic [5:0]       attackStepCode,
  output logic [20:0]      attackIntervalCycles,
  output logic [5:0]       releaseStepCode,
  output logic [5:0]       holdStepCode,
  output logic [5:0]       staticGainCode,
  output logic signed [6:0] staticGainDb,
  output logic             limiterOff,
  output logic [1:0]       gateThreshold,
  output logic [4:0]       limiterLevel,
  output logic [3:0]       maxGain,
  output logic [1:0]       compressionRatio,
  output logic             faultFlag,
  output logic             thermalFlag
);

  ////////////////////////////////////////////////////////////////////////////
  // register defaults and read mux

  // load defaults into the register bank and idle the slave
  function automatic aagc_dev_s setDefaults(input aagc_dev_s s);
    aagc_dev_s r;
    logic [7:0] d1;
    r = s;
    d1 = `AAGC_DEF_R1;
    r.ampEn = d1[`AAGC_R1_EN];
    r.softSd = d1[`AAGC_R1_SD];
    r.fault = d1[`AAGC_R1_FAULT];
    r.thermal = d1[`AAGC_R1_HOT];
    r.ngOn = d1[`AAGC_R1_NG];
    r.atk = 6'(`AAGC_DEF_R2);
    r.rel = 6'(`AAGC_DEF_R3);
    r.hold = 6'(`AAGC_DEF_R4);
    r.gain = 6'(`AAGC_DEF_R5);
    r.lim = `AAGC_DEF_R6;
    r.mgr = `AAGC_DEF_R7;
    r.state = DEV_IDLE;
    r.bitCnt = 4'h0;
    r.sdaOe = 1'b0;
    r.ptr = 8'h00;
    return r;
  endfunction : setDefaults

  // assemble a register image; unmapped locations read zero
  function automatic logic [7:0] readReg(input aagc_dev_s s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      8'h01: begin
        v[`AAGC_R1_FIX1] = 1'b1;
        v[`AAGC_R1_FIX2] = 1'b1;
        v[`AAGC_R1_EN] = s.ampEn;
        v[`AAGC_R1_SD] = s.softSd;
        v[`AAGC_R1_FAULT] = s.fault;
        v[`AAGC_R1_HOT] = s.thermal;
        v[`AAGC_R1_NG] = s.ngOn;
      end
      8'h02: v = {2'h0, s.atk};
      8'h03: v = {2'h0, s.rel};
      8'h04: v = {2'h0, s.hold};
      8'h05: v = {2'h0, s.gain};
      8'h06: v = s.lim;
      8'h07: v = s.mgr & `AAGC_R7_MASK;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : readReg

  localparam aagc_dev_s RST_STATE = setDefaults('0);

  aagc_dev_s st;
  aagc_dev_s n;
  logic      rise;
  logic      fall;
  logic      startC;
  logic      stopC;
  logic      hot;
  logic [7:0] txNext;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  // synchronise, decode the link and update registers
  always_comb begin
    n = st;
    txNext = 8'h00;
    n.sclS = {st.sclS[0], bus.scl};
    n.sdaS = {st.sdaS[0], bus.sda};
    n.enS = {st.enS[0], enablePin};
    n.shortS = {st.shortS[0], shortEvent};
    n.hotS = {st.hotS[0], overTemp};
    n.sclP = st.sclS[1];
    n.sdaP = st.sdaS[1];
    rise = st.sclS[1] & ~st.sclP;
    fall = ~st.sclS[1] & st.sclP;
    startC = st.sclS[1] & st.sclP & st.sdaP & ~st.sdaS[1];
    stopC = st.sclS[1] & st.sclP & ~st.sdaP & st.sdaS[1];
    // deglitch the over-temperature level
    if (!st.hotS[1]) begin
      n.hotCnt = 4'h0;
    end else if (st.hotCnt != `AAGC_DEGLITCH) begin
      n.hotCnt = st.hotCnt + 4'h1;
    end
    hot = (st.hotCnt == `AAGC_DEGLITCH);
    // serial protocol
    if (startC) begin
      n.state = DEV_ADDR;
      n.bitCnt = 4'h0;
      n.sdaOe = 1'b0;
    end else if (stopC) begin
      n.state = DEV_IDLE;
      n.sdaOe = 1'b0;
    end else if (rise && st.state != DEV_IDLE) begin
      n.shift = {st.shift[6:0], st.sdaS[1]};
      n.bitCnt = (st.bitCnt == `AAGC_BIT_ACK) ? 4'h0 : st.bitCnt + 4'h1;
      if (st.state == DEV_RDATA && st.bitCnt == `AAGC_BIT_ACK) begin
        if (st.sdaS[1]) begin
          n.state = DEV_WAIT;
        end else begin
          n.ptr = st.ptr + 8'h01;
          n.tx = readReg(st, st.ptr + 8'h01);
        end
      end
    end else if (fall) begin
      if (st.state == DEV_RDATA && st.bitCnt != `AAGC_BIT_ACK) begin
        n.sdaOe = ~st.tx[7];
        n.tx = {st.tx[6:0], 1'b0};
      end else if (st.bitCnt == `AAGC_BIT_ACK) begin
        n.sdaOe = 1'b0;
        case (st.state)
          DEV_ADDR: begin
            if (st.shift == `AAGC_ADDR_WR) begin
              n.sdaOe = 1'b1;
            end else if (st.shift == `AAGC_ADDR_RD) begin
              n.sdaOe = 1'b1;
              n.state = DEV_ACKRD;
            end else begin
              n.state = DEV_WAIT;
            end
          end
          DEV_REG: begin
            n.ptr = st.shift;
            n.sdaOe = 1'b1;
          end
          DEV_WDATA: begin
            case (st.ptr)
              8'h01: begin
                n.ampEn = st.shift[`AAGC_R1_EN];
                n.softSd = st.shift[`AAGC_R1_SD];
                n.ngOn = st.shift[`AAGC_R1_NG];
                n.fault = st.fault & st.shift[`AAGC_R1_FAULT];
                n.thermal = st.thermal & st.shift[`AAGC_R1_HOT];
              end
              8'h02: n.atk = st.shift[5:0];
              8'h03: n.rel = st.shift[5:0];
              8'h04: n.hold = st.shift[5:0];
              8'h05: n.gain = st.shift[5:0];
              8'h06: n.lim = st.shift;
              8'h07: n.mgr = st.shift & `AAGC_R7_MASK;
              default: ;
            endcase
            n.ptr = st.ptr + 8'h01;
            n.sdaOe = 1'b1;
          end
          default: ;
        endcase
      end else if (st.bitCnt == 4'h0 && st.sdaOe) begin
        n.sdaOe = 1'b0;
        case (st.state)
          DEV_ADDR: n.state = DEV_REG;
          DEV_REG: n.state = DEV_WDATA;
          DEV_ACKRD: begin
            n.state = DEV_RDATA;
            txNext = readReg(st, st.ptr);
            n.sdaOe = ~txNext[7];
            n.tx = {txNext[6:0], 1'b0};
          end
          default: ;
        endcase
      end
    end
    // hardware events win over a clearing write
    n.fault = n.fault | st.shortS[1];
    n.thermal = n.thermal | hot;
    if (!st.enS[1]) begin
      n = setDefaults(n);
    end
    // derived outputs
    n.ampActive = n.ampEn & ~n.softSd & ~hot & st.enS[1];
    n.ngActive = n.ngOn & (n.mgr[1:0] != `AAGC_RATIO_1TO1) & ~n.softSd;
    n.atkCycles = 21'(n.atk * ATK_STEP_CYC);
    n.gainDb = {n.gain[5], n.gain};
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= RST_STATE;
    end else begin
      st <= n;
    end
  end

  // outputs straight from the state flops
  assign bus.devSdaOe = st.sdaOe;
  assign ampActive = st.ampActive;
  assign softShutdown = st.softSd;
  assign noiseGateOn = st.ngOn;
  assign noiseGateActive = st.ngActive;
  assign attackStepCode = st.atk;
  assign attackIntervalCycles = st.atkCycles;
  assign releaseStepCode = st.rel;
  assign holdStepCode = st.hold;
  assign staticGainCode = st.gain;
  assign staticGainDb = st.gainDb;
  assign limiterOff = st.lim[7];
  assign gateThreshold = st.lim[6:5];
  assign limiterLevel = st.lim[4:0];
  assign maxGain = st.mgr[7:4];
  assign compressionRatio = st.mgr[1:0];
  assign faultFlag = st.fault;
  assign thermalFlag = st.thermal;

endmodule : aagc_device

// ==== aagc_defines.svh ====
// constants for the amplifier control register bank and its serial link
`ifndef AAGC_DEFINES_SVH
`define AAGC_DEFINES_SVH
`define AAGC_ADDR_WR      8'hB0
`define AAGC_ADDR_RD      8'hB1
`define AAGC_REG_FIRST    8'h01
`define AAGC_REG_LAST     8'h07
`define AAGC_DEF_R1       8'hC3
`define AAGC_DEF_R2       8'h05
`define AAGC_DEF_R3       8'h0B
`define AAGC_DEF_R4       8'h00
`define AAGC_DEF_R5       8'h06
`define AAGC_DEF_R6       8'h3A
`define AAGC_DEF_R7       8'hC2
`define AAGC_R1_FIX1      7
`define AAGC_R1_EN        6
`define AAGC_R1_SD        5
`define AAGC_R1_FIX0      4
`define AAGC_R1_FAULT     3
`define AAGC_R1_HOT       2
`define AAGC_R1_FIX2      1
`define AAGC_R1_NG        0
`define AAGC_R7_MASK      8'hF3
`define AAGC_RATIO_1TO1   2'h0
`define AAGC_DEGLITCH     4'hF
`define AAGC_BIT_ACK      4'h8
`define AAGC_CLK_NS       5
`define AAGC_ATK_STEP_PS  106700000
`define AAGC_SCL_QTR_NS   625
`endif

// ==== aagc_pkg.sv ====
// state types for both ends of the register bank link
`include "aagc_defines.svh"
package aagc_pkg;
  typedef enum logic [6:0] {
    DEV_IDLE  = 7'h01,
    DEV_ADDR  = 7'h02,
    DEV_REG   = 7'h04,
    DEV_WDATA = 7'h08,
    DEV_ACKRD = 7'h10,
    DEV_RDATA = 7'h20,
    DEV_WAIT  = 7'h40
  } aagc_dev_e;

  typedef enum logic [3:0] {
    HST_IDLE  = 4'h1,
    HST_START = 4'h2,
    HST_BIT   = 4'h4,
    HST_STOP  = 4'h8
  } aagc_hst_e;

  typedef struct packed {
    logic [1:0]  sclS;
    logic [1:0]  sdaS;
    logic        sclP;
    logic        sdaP;
    logic [1:0]  enS;
    logic [1:0]  shortS;
    logic [1:0]  hotS;
    logic [3:0]  hotCnt;
    aagc_dev_e   state;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic [7:0]  tx;
    logic [7:0]  ptr;
    logic        sdaOe;
    logic        ampEn;
    logic        softSd;
    logic        fault;
    logic        thermal;
    logic        ngOn;
    logic [5:0]  atk;
    logic [5:0]  rel;
    logic [5:0]  hold;
    logic [5:0]  gain;
    logic [7:0]  lim;
    logic [7:0]  mgr;
    logic        ampActive;
    logic        ngActive;
    logic [20:0] atkCycles;
    logic [6:0]  gainDb;
  } aagc_dev_s;

  typedef struct packed {
    aagc_hst_e   state;
    logic [15:0] divCnt;
    logic [1:0]  q;
    logic [2:0]  step;
    logic [3:0]  bitIdx;
    logic [7:0]  txByte;
    logic [7:0]  rxByte;
    logic        rxMode;
    logic [3:0]  left;
    logic        rd;
    logic [7:0]  regAddr;
    logic [7:0]  data;
    logic [1:0]  sdaS;
    logic        sclOe;
    logic        sdaOe;
    logic        busy;
    logic        rdValid;
    logic [7:0]  rdData;
    logic        nack;
  } aagc_hst_s;
endpackage : aagc_pkg

// ==== aagc_if.sv ====
// open-drain two-wire link joining the controller and the amplifier
interface aagc_if;
  logic hostSclOe;
  logic hostSdaOe;
  logic devSdaOe;
  logic scl;
  logic sda;

  // pull-ups: a line is low while any end enables its driver
  assign scl = ~hostSclOe;
  assign sda = ~(hostSdaOe | devSdaOe);

  modport host (output hostSclOe, output hostSdaOe, input scl, input sda);
  modport dev  (output devSdaOe, input scl, input sda);
endinterface : aagc_if

// ==== aagc_host.sv ====
// controller end: serial master issuing register writes and reads
`include "aagc_defines.svh"
module aagc_host
  import aagc_pkg::*;
#(
  parameter int QTR_CYC = (`AAGC_SCL_QTR_NS + `AAGC_CLK_NS - 1) / `AAGC_CLK_NS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // link
  aagc_if.host            bus,
  // command port
  input  wire logic       cmdValid,
  input  wire logic       cmdRead,
  input  wire logic [7:0] cmdReg,
  input  wire logic [7:0] cmdData,
  input  wire logic [3:0] cmdCount,
  // status port
  output logic            busy,
  output logic            rdValid,
  output logic [7:0]      rdData,
  output logic            nack
);

  localparam aagc_hst_s RST_STATE = '{state: HST_IDLE, default: '0};

  aagc_hst_s st;
  aagc_hst_s n;
  logic      tick;

  // start a byte on the wire
  function automatic aagc_hst_s beginByte(input aagc_hst_s s, input logic [7:0] b,
                                          input logic rx);
    aagc_hst_s r;
    r = s;
    r.state = HST_BIT;
    r.bitIdx = 4'h0;
    r.txByte = b;
    r.rxMode = rx;
    return r;
  endfunction : beginByte

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  // quarter-bit sequencer for start, bits and stop
  always_comb begin
    n = st;
    n.sdaS = {st.sdaS[0], bus.sda};
    n.rdValid = 1'b0;
    tick = (st.divCnt == 16'(QTR_CYC - 1));
    n.divCnt = tick ? 16'h0000 : st.divCnt + 16'h0001;
    case (st.state)
      HST_IDLE: begin
        n.q = 2'h0;
        if (cmdValid) begin
          n.state = HST_START;
          n.step = 3'h0;
          n.rd = cmdRead;
          n.regAddr = cmdReg;
          n.data = cmdData;
          n.left = (cmdCount == 4'h0) ? 4'h1 : cmdCount;
          n.busy = 1'b1;
          n.nack = 1'b0;
          n.divCnt = 16'h0000;
        end
      end
      HST_START: if (tick) begin
        n.q = st.q + 2'h1;
        case (st.q)
          2'h0: n.sdaOe = 1'b0;
          2'h1: n.sclOe = 1'b0;
          2'h2: n.sdaOe = 1'b1;
          default: begin
            n.sclOe = 1'b1;
            if (st.step == 3'h0) begin
              n = beginByte(n, `AAGC_ADDR_WR, 1'b0);
              n.step = 3'h1;
            end else begin
              n = beginByte(n, `AAGC_ADDR_RD, 1'b0);
              n.step = 3'h4;
            end
          end
        endcase
      end
      HST_BIT: if (tick) begin
        n.q = st.q + 2'h1;
        case (st.q)
          2'h0: begin
            if (st.bitIdx == `AAGC_BIT_ACK) begin
              n.sdaOe = st.rxMode & (st.left != 4'h1);
            end else begin
              n.sdaOe = ~st.rxMode & ~st.txByte[7];
              n.txByte = {st.txByte[6:0], 1'b0};
            end
          end
          2'h1: n.sclOe = 1'b0;
          2'h2: begin
            if (st.bitIdx != `AAGC_BIT_ACK) begin
              n.rxByte = {st.rxByte[6:0], st.sdaS[1]};
            end else if (!st.rxMode && st.sdaS[1]) begin
              n.nack = 1'b1;
            end
          end
          default: begin
            n.sclOe = 1'b1;
            n.bitIdx = st.bitIdx + 4'h1;
            if (st.bitIdx == `AAGC_BIT_ACK) begin
              n.sdaOe = 1'b0;
              if (n.nack) begin
                n.state = HST_STOP;
              end else begin
                case (st.step)
                  3'h1: begin
                    n = beginByte(n, st.regAddr, 1'b0);
                    n.step = 3'h2;
                  end
                  3'h2: begin
                    if (st.rd) begin
                      n.state = HST_START;
                      n.step = 3'h3;
                    end else begin
                      n = beginByte(n, st.data, 1'b0);
                      n.step = 3'h5;
                    end
                  end
                  3'h4: begin
                    n = beginByte(n, 8'h00, 1'b1);
                    n.step = 3'h6;
                  end
                  3'h6: begin
                    n.rdValid = 1'b1;
                    n.rdData = st.rxByte;
                    n.left = st.left - 4'h1;
                    if (st.left == 4'h1) begin
                      n.state = HST_STOP;
                    end else begin
                      n = beginByte(n, 8'h00, 1'b1);
                    end
                  end
                  default: n.state = HST_STOP;
                endcase
              end
            end
          end
        endcase
      end
      HST_STOP: if (tick) begin
        n.q = st.q + 2'h1;
        case (st.q)
          2'h0: n.sdaOe = 1'b1;
          2'h1: n.sclOe = 1'b0;
          2'h2: n.sdaOe = 1'b0;
          default: begin
            n.state = HST_IDLE;
            n.busy = 1'b0;
          end
        endcase
      end
      default: n = RST_STATE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= RST_STATE;
    end else begin
      st <= n;
    end
  end

  // outputs straight from the state flops
  assign bus.hostSclOe = st.sclOe;
  assign bus.hostSdaOe = st.sdaOe;
  assign busy = st.busy;
  assign rdValid = st.rdValid;
  assign rdData = st.rdData;
  assign nack = st.nack;

endmodule : aagc_host

// ==== aagc_link_asserts.sv ====
// wire-level checks of the amplifier end of the two-wire link
`include "aagc_defines.svh"
module aagc_link_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link wires
  input wire logic hostSclOe,
  input wire logic hostSdaOe,
  input wire logic devSdaOe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclQ;
  logic       sdaQ;
  logic       nacked;
  logic [7:0] addr;
  int         cnt;
  wire logic  rise;
  wire logic  frame;

  // clock rise, and start or stop while the clock is high
  assign rise  = scl && !sclQ;
  assign frame = scl && sclQ && (sda != sdaQ);

  //////////////////////////////////////////////////////////////////////////////
  // rise counter, address capture and master nack memory
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclQ   <= 1'b1;
      sdaQ   <= 1'b1;
      nacked <= 1'b0;
      addr   <= 8'h00;
      cnt    <= 0;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
      if (frame) begin
        cnt    <= 0;
        nacked <= 1'b0;
      end else if (rise) begin
        cnt <= cnt + 1;
        if (cnt < 8) begin
          addr <= {addr[6:0], sda};
        end
        if (addr == `AAGC_ADDR_RD && cnt > 8 && cnt % 9 == 8 && sda) begin
          nacked <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // device data moves only in the clock low phase
  property p_dev_change_low;
    $changed(devSdaOe) |-> !scl && !$past(scl);
  endproperty
  a_dev_change_low: assert property (p_dev_change_low) else $error("data moved, clock high");
  property p_dev_stable_high;
    scl && $past(scl) |-> $stable(devSdaOe);
  endproperty
  a_dev_stable_high: assert property (p_dev_stable_high) else $error("data unstable");
  // silent while the address byte arrives
  property p_addr_silent;
    rise && cnt < 8 |-> !devSdaOe;
  endproperty
  a_addr_silent: assert property (p_addr_silent) else $error("drove during address");
  // every ninth clock of a write is acknowledged
  property p_wr_ack;
    rise && addr == `AAGC_ADDR_WR && cnt % 9 == 8 |-> devSdaOe;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write byte not acknowledged");
  property p_wr_silent;
    rise && addr == `AAGC_ADDR_WR && cnt > 8 && cnt % 9 != 8 |-> !devSdaOe;
  endproperty
  a_wr_silent: assert property (p_wr_silent) else $error("drove during write data");
  // read address acknowledged for four clocks from the clock rise
  property p_rd_addr_ack;
    rise && addr == `AAGC_ADDR_RD && cnt == 8 |-> devSdaOe [*4];
  endproperty
  a_rd_addr_ack: assert property (p_rd_addr_ack) else $error("read address not acknowledged");
  property p_rd_release;
    rise && addr == `AAGC_ADDR_RD && cnt > 8 && cnt % 9 == 8 |-> !devSdaOe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("drove in master ack clock");
  property p_nack_quiet;
    nacked |-> !devSdaOe;
  endproperty
  a_nack_quiet: assert property (p_nack_quiet) else $error("drove after master nack");
endmodule : aagc_link_asserts

// ==== amp_agc_i2c_register_bank_test.sv ====
// self-checking bench: controller and amplifier ends joined over the link
`include "aagc_defines.svh"
module amp_agc_i2c_register_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, reset, enablePin, shortEvent, overTemp;
  logic              cmdValid, cmdRead, busy, rdValid, nack;
  logic [7:0]        cmdReg, cmdData, rdData;
  logic [3:0]        cmdCount, maxGain;
  logic              ampActive, softShutdown, noiseGateOn, noiseGateActive;
  logic              limiterOff, faultFlag, thermalFlag;
  logic [5:0]        attackStepCode, releaseStepCode, holdStepCode, staticGainCode;
  logic [20:0]       attackIntervalCycles;
  logic signed [6:0] staticGainDb;
  logic [1:0]        gateThreshold, compressionRatio;
  logic [4:0]        limiterLevel;
  logic [7:0]        model [1:7];
  logic [7:0]        rxq [$];
  logic [31:0]       lfsrState;
  int                fails, comparisons;

  // both ends on one link, checker beside it
  aagc_if aagc_if_i ();
  aagc_device #(.ATK_STEP_CYC(4)) aagc_device_i (.clk(clk), .reset(reset), .bus(aagc_if_i.dev),
    .enablePin(enablePin), .shortEvent(shortEvent), .overTemp(overTemp), .ampActive(ampActive),
    .softShutdown(softShutdown), .noiseGateOn(noiseGateOn), .noiseGateActive(noiseGateActive),
    .attackStepCode(attackStepCode), .attackIntervalCycles(attackIntervalCycles),
    .releaseStepCode(releaseStepCode), .holdStepCode(holdStepCode),
    .staticGainCode(staticGainCode), .staticGainDb(staticGainDb), .limiterOff(limiterOff),
    .gateThreshold(gateThreshold), .limiterLevel(limiterLevel), .maxGain(maxGain),
    .compressionRatio(compressionRatio), .faultFlag(faultFlag), .thermalFlag(thermalFlag));
  aagc_host #(.QTR_CYC(8)) aagc_host_i (.clk(clk), .reset(reset), .bus(aagc_if_i.host),
    .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdReg(cmdReg), .cmdData(cmdData),
    .cmdCount(cmdCount), .busy(busy), .rdValid(rdValid), .rdData(rdData), .nack(nack));
  aagc_link_asserts aagc_link_asserts_i (.clk(clk), .reset(reset),
    .hostSclOe(aagc_if_i.hostSclOe), .hostSdaOe(aagc_if_i.hostSdaOe),
    .devSdaOe(aagc_if_i.devSdaOe), .scl(aagc_if_i.scl), .sda(aagc_if_i.sda));

  // 200 MHz clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // register contents after a write
  function automatic logic [7:0] after_write(input logic [7:0] r, d, old);
    case (r)
      8'h01: return {1'b1, d[6:5], 1'b0, d[3:2] & old[3:2], 1'b1, d[0]};
      8'h06: return d;
      8'h07: return d & 8'hF3;
      default: return d & 8'h3F;
    endcase
  endfunction : after_write

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // one command, then wait for the link to go idle while collecting bytes
  task automatic send(input logic rd, input logic [7:0] r, d, input logic [3:0] c);
    int n;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdRead  <= rd;
    cmdReg   <= r;
    cmdData  <= d;
    cmdCount <= c;
    @(posedge clk);
    cmdValid <= 1'b0;
    repeat (2) @(posedge clk);
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge clk);
      if (rdValid === 1'b1) rxq.push_back(rdData);
      n++;
    end
    // leave on a rising edge so the next drive lands on one
    @(posedge clk);
    if (n >= 20000) fails++;
    check(nack, 1'b0);
  endtask : send

  task automatic wr(input logic [7:0] r, d);
    send(1'b0, r, d, 4'h1);
    if (r >= 8'h01 && r <= 8'h07) model[r[2:0]] = after_write(r, d, model[r[2:0]]);
  endtask : wr

  task automatic rd(input logic [7:0] r, input int c);
    logic [7:0] a;
    rxq.delete();
    send(1'b1, r, 8'h00, 4'(c));
    check(32'(rxq.size()), 32'(c));
    for (int i = 0; i < rxq.size(); i++) begin
      a = r + 8'(i);
      check(rxq[i], (a >= 8'h01 && a <= 8'h07) ? model[a[2:0]] : 8'h00);
    end
  endtask : rd

  // control outputs against the modelled registers
  task automatic check_outs;
    check(attackStepCode, model[2][5:0]);
    check(attackIntervalCycles, 32'(model[2][5:0]) * 4);
    check(releaseStepCode, model[3][5:0]);
    check(holdStepCode, model[4][5:0]);
    check(staticGainCode, model[5][5:0]);
    check({25'h0, staticGainDb}, {25'h0, model[5][5], model[5][5:0]});
    check({limiterOff, gateThreshold, limiterLevel}, model[6]);
    check({maxGain, 2'b00, compressionRatio}, model[7] & 8'hF3);
    check(softShutdown, model[1][5]);
    check(noiseGateOn, model[1][0]);
    check(noiseGateActive, model[1][0] & (model[7][1:0] != 2'b00) & ~model[1][5]);
    check(ampActive, model[1][6] & ~model[1][5]);
    check({faultFlag, thermalFlag}, model[1][3:2]);
  endtask : check_outs

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    fails = 0;
    comparisons = 0;
    lfsrState = 32'h050c;
    {reset, enablePin, shortEvent, overTemp, cmdValid, cmdRead} = 6'h30;
    {cmdReg, cmdData, cmdCount} = 20'h0;
    model = '{8'hC3, 8'h05, 8'h0B, 8'h00, 8'h06, 8'h3A, 8'hC2};
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(8'h01, 7);
    check_outs;
    for (int k = 0; k < 12; k++) begin
      lfsrState = lfsr_next(lfsrState);
      wr((k == 0) ? 8'h00 : 8'(lfsrState[15:8] % 7 + 1), lfsrState[7:0]);
    end
    rd(8'h01, 7);
    check_outs;
    wr(8'h01, 8'hFF);
    check_outs;
    wr(8'h01, 8'h41);
    for (int r = 0; r < 4; r++) begin
      wr(8'h07, 8'hAC | 8'(r));
      check_outs;
    end
    // sticky short flag
    shortEvent <= 1'b1;
    repeat (4) @(posedge clk);
    shortEvent <= 1'b0;
    repeat (6) @(posedge clk);
    model[1][3] = 1'b1;
    check(faultFlag, 1'b1);
    wr(8'h01, model[1] | 8'h0C);
    // a short glitch of over-temperature is ignored, a long one trips
    overTemp <= 1'b1;
    repeat (10) @(posedge clk);
    overTemp <= 1'b0;
    repeat (8) @(posedge clk);
    check(thermalFlag, 1'b0);
    overTemp <= 1'b1;
    repeat (24) @(posedge clk);
    check(ampActive, 1'b0);
    overTemp <= 1'b0;
    repeat (8) @(posedge clk);
    model[1][2] = 1'b1;
    rd(8'h01, 1);
    wr(8'h01, 8'h41);
    rd(8'h01, 1);
    check_outs;
    rd(8'h06, 3);
    // enable pin low restores every default, sticky flag too
    shortEvent <= 1'b1;
    repeat (4) @(posedge clk);
    shortEvent <= 1'b0;
    repeat (6) @(posedge clk);
    check(faultFlag, 1'b1);
    enablePin <= 1'b0;
    repeat (8) @(posedge clk);
    enablePin <= 1'b1;
    repeat (8) @(posedge clk);
    model = '{8'hC3, 8'h05, 8'h0B, 8'h00, 8'h06, 8'h3A, 8'hC2};
    rd(8'h01, 7);
    check_outs;
    report_and_stop();
  end

  // watchdog against a hung link
  initial begin
    #450000;
    fails++;
    report_and_stop();
  end
endmodule : amp_agc_i2c_register_bank_test
